// >>> common/bus488_pkg.sv
// Shared constants and state types for both ends of the instrument bus port.
// Assumes a single 100 MHz clock in every module that imports it.
package bus488_pkg;

    // ----------------------------------------------------------------
    // Addressing and interface messages
    // ----------------------------------------------------------------
    localparam logic [4:0] ADDR_MAX = 5'h1e;
    localparam logic [4:0] ADDR_UN = 5'h1f;
    localparam logic [1:0] GRP_LISTEN = 2'h1;
    localparam logic [1:0] GRP_TALK = 2'h2;
    localparam logic [6:0] MSG_GTL = 7'h01;
    localparam logic [6:0] MSG_SDC = 7'h04;
    localparam logic [6:0] MSG_GET = 7'h08;
    localparam logic [6:0] MSG_LLO = 7'h11;
    localparam logic [6:0] MSG_DCL = 7'h14;
    localparam logic [6:0] MSG_SPE = 7'h18;
    localparam logic [6:0] MSG_SPD = 7'h19;
    localparam int SB_RSV = 6;

    // ----------------------------------------------------------------
    // Command characters
    // ----------------------------------------------------------------
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_SEMI = 8'h3b;
    localparam logic [7:0] CH_0 = 8'h30;
    localparam logic [7:0] CH_9 = 8'h39;
    localparam logic [7:0] CH_A = 8'h41;
    localparam logic [7:0] CH_Z = 8'h5a;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int SETTLE_NS = 2000;
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int IFC_US = 100;
    localparam int IFC_CYC = IFC_US * CLK_MHZ;

    // ----------------------------------------------------------------
    // Controller register map
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TX = 8'h04;
    localparam logic [7:0] REG_RX = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0c;
    localparam logic [7:0] REG_IRQ_STAT = 8'h10;
    localparam logic [7:0] REG_IRQ_MASK = 8'h14;
    localparam int CTRL_REN = 0;
    localparam int CTRL_ATN = 1;
    localparam int CTRL_LISTEN = 2;
    localparam int CTRL_IFC = 3;
    localparam int TX_EOI = 8;
    localparam int EV_TX_DONE = 0;
    localparam int EV_RX = 1;
    localparam int EV_SRQ = 2;

    typedef enum logic {AH_RDY, AH_HOLD} ah_state_t;
    typedef enum logic [1:0] {SH_IDLE, SH_SETTLE, SH_DAV} sh_state_t;
    typedef enum logic [1:0] {P_CMD, P_PARAM, P_BAD} parse_state_t;

endpackage

// >>> common/bus488_if.sv
// Instrument bus wiring between the device end and the controller end.
// Each open-drain line is driven through out and active-low enable; levels are true-asserted.
`timescale 1ns/1ps
interface bus488_if;
    logic [7:0] dev_dio_o, dev_dio_oe_n, ctl_dio_o, ctl_dio_oe_n;
    logic dev_dav_o, dev_dav_oe_n, ctl_dav_o, ctl_dav_oe_n;
    logic dev_eoi_o, dev_eoi_oe_n, ctl_eoi_o, ctl_eoi_oe_n;
    logic dev_nrfd_o, dev_nrfd_oe_n, ctl_nrfd_o, ctl_nrfd_oe_n;
    logic dev_ndac_o, dev_ndac_oe_n, ctl_ndac_o, ctl_ndac_oe_n;
    logic dev_srq_o, dev_srq_oe_n;
    logic ctl_atn, ctl_ifc, ctl_ren;
    logic [7:0] dio;
    logic dav, eoi, nrfd, ndac, srq, atn, ifc, ren;

    // ----------------------------------------------------------------
    // Wired-or resolution of the shared lines
    // ----------------------------------------------------------------
    assign dio = (~dev_dio_oe_n & dev_dio_o) | (~ctl_dio_oe_n & ctl_dio_o);
    assign dav = (~dev_dav_oe_n & dev_dav_o) | (~ctl_dav_oe_n & ctl_dav_o);
    assign eoi = (~dev_eoi_oe_n & dev_eoi_o) | (~ctl_eoi_oe_n & ctl_eoi_o);
    assign nrfd = (~dev_nrfd_oe_n & dev_nrfd_o) | (~ctl_nrfd_oe_n & ctl_nrfd_o);
    assign ndac = (~dev_ndac_oe_n & dev_ndac_o) | (~ctl_ndac_oe_n & ctl_ndac_o);
    assign srq = ~dev_srq_oe_n & dev_srq_o;
    assign atn = ctl_atn;
    assign ifc = ctl_ifc;
    assign ren = ctl_ren;

    modport dev (input dio, dav, eoi, nrfd, ndac, atn, ifc, ren,
        output dev_dio_o, dev_dio_oe_n, dev_dav_o, dev_dav_oe_n, dev_eoi_o, dev_eoi_oe_n,
        dev_nrfd_o, dev_nrfd_oe_n, dev_ndac_o, dev_ndac_oe_n, dev_srq_o, dev_srq_oe_n);
    modport ctl (input dio, dav, eoi, nrfd, ndac, srq,
        output ctl_dio_o, ctl_dio_oe_n, ctl_dav_o, ctl_dav_oe_n, ctl_eoi_o, ctl_eoi_oe_n,
        ctl_nrfd_o, ctl_nrfd_oe_n, ctl_ndac_o, ctl_ndac_oe_n, ctl_atn, ctl_ifc, ctl_ren);
endinterface

// >>> hdl/remote_port_dev.sv
// Device end of the instrument bus: listener, talker, command parser, remote/local.
// Assumes bus lines synchronous to REF_CLK and the instrument core on the user ports.
`timescale 1ns/1ps
// Summary of operation
// RULE1: Respond only to addresses derived from 0..30.
// RULE2: Execute data bytes only while attention is false.
// RULE3: Command ends on LF, CR LF, EOI or semicolon.
// RULE4: Command is one or two upper-case letters.
// RULE5: Parameter digits are converted to a number.
// RULE6: Remote commands reach every panel function.
// RULE7: Talker sends setup data, status byte, status.
// RULE8: Full handshakes, SRQ, RL, DC, DT; no PP.
// RULE9: Own listen address drops talker state.
// RULE10: Own talk address drops listener state.
// RULE11: Interface clear drops talker and listener.
// RULE12: Addressed with REN goes remote; GTL goes local. Only own listen address sets remote; own talk address does not.
// RULE13: Device clear restores power-up panel settings.
// RULE14: Trigger applies pending output commands like execute.
// RULE15: Lockout disables the local key.
// RULE16: Remote lights indicator, ignores other panel keys.
// RULE17: Local key leaves remote unless locked out.
// RULE18: Reset gives local, unaddressed, empty command buffer.
module remote_port_dev
    import bus488_pkg::*;
#(
    parameter int PARAM_W = 32
)
(
    bus488_if.dev BUS,
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [4:0] ADDR,
    input wire logic LOCAL_KEY,
    input wire logic PANEL_KEY,
    output logic PANEL_KEY_OK,
    output logic REMOTE_LED,
    output logic LOCKOUT,
    output logic TALKER,
    output logic LISTENER,
    output logic CMD_VALID,
    output logic CMD_ERROR,
    output logic [15:0] CMD_CODE,
    output logic [PARAM_W-1:0] CMD_PARAM,
    output logic EXEC_TRIG,
    output logic PANEL_RESET,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_LAST,
    input wire logic TX_VALID,
    output logic TX_READY,
    input wire logic [7:0] STATUS_BYTE,
    input wire logic SRQ_REQ
);
    logic lads_ff, tads_ff, spm_ff, remote_ff, llo_ff, rsv_ff;
    ah_state_t ah_ff;
    sh_state_t sh_ff;
    parse_state_t ps_ff, nxt_ps;
    logic [1:0] nch_ff, nxt_nch;
    logic [15:0] code_ff, nxt_code;
    logic [PARAM_W-1:0] val_ff, nxt_val;
    logic [15:0] settle_ff;
    logic [7:0] out_byte_ff;
    logic out_eoi_ff, have_ff, is_sb_ff, sb_sent_ff;
    logic addr_ok, active, take, cmd_take, dat_take, my_la, my_ta, unl, talk_grp;
    logic is_let, is_dig, done, talking, drive, sent, dev_clr;
    logic [6:0] b7;

    // ----------------------------------------------------------------
    // Acceptor handshake and address decode
    // ----------------------------------------------------------------
    assign addr_ok = ADDR <= ADDR_MAX; // RULE1
    assign active = BUS.atn | lads_ff;
    assign take = active & BUS.dav & (ah_ff == AH_RDY);
    assign b7 = BUS.dio[6:0];
    assign cmd_take = take & BUS.atn;
    assign dat_take = take & ~BUS.atn & lads_ff; // RULE2
    assign talk_grp = cmd_take & (b7[6:5] == GRP_TALK);
    assign my_la = cmd_take & (b7[6:5] == GRP_LISTEN) & (b7[4:0] == ADDR) & addr_ok; // RULE1
    assign my_ta = talk_grp & (b7[4:0] == ADDR) & addr_ok; // RULE1
    assign unl = cmd_take & (b7[6:5] == GRP_LISTEN) & (b7[4:0] == ADDR_UN);
    assign dev_clr = cmd_take & ((b7 == MSG_DCL) | ((b7 == MSG_SDC) & lads_ff));

    always_ff @(posedge REF_CLK)
    begin
        if (RST || !active)
            ah_ff <= AH_RDY;
        else if (take)
            ah_ff <= AH_HOLD; // RULE8
        else if (ah_ff == AH_HOLD && !BUS.dav)
            ah_ff <= AH_RDY;
    end

    assign BUS.dev_nrfd_o = 1'b1;
    assign BUS.dev_nrfd_oe_n = ~(active & (ah_ff == AH_HOLD));
    assign BUS.dev_ndac_o = 1'b1;
    assign BUS.dev_ndac_oe_n = ~(active & (ah_ff == AH_RDY));

    always_ff @(posedge REF_CLK)
    begin
        if (RST || BUS.ifc)
        begin
            lads_ff <= 1'b0; // RULE11 RULE18
            tads_ff <= 1'b0; // RULE11 RULE18
        end
        else if (my_la)
        begin
            lads_ff <= 1'b1;
            tads_ff <= 1'b0; // RULE9
        end
        else if (my_ta)
        begin
            tads_ff <= 1'b1;
            lads_ff <= 1'b0; // RULE10
        end
        else if (unl)
            lads_ff <= 1'b0;
        else if (talk_grp)
            tads_ff <= 1'b0;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST || BUS.ifc)
            spm_ff <= 1'b0;
        else if (cmd_take && b7 == MSG_SPE)
            spm_ff <= 1'b1; // RULE7
        else if (cmd_take && b7 == MSG_SPD)
            spm_ff <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Remote, local and lockout
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK)
    begin
        if (RST || !BUS.ren)
        begin
            remote_ff <= 1'b0; // RULE18
            llo_ff <= 1'b0; // RULE18
        end
        else
        begin
            if (cmd_take && b7 == MSG_LLO)
                llo_ff <= 1'b1; // RULE15
            if (my_la)
                remote_ff <= 1'b1; // RULE12
            else if (cmd_take && b7 == MSG_GTL && lads_ff)
                remote_ff <= 1'b0; // RULE12
            else if (LOCAL_KEY && !llo_ff)
                remote_ff <= 1'b0; // RULE15 RULE17
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            PANEL_KEY_OK <= 1'b0;
            PANEL_RESET <= 1'b0;
            EXEC_TRIG <= 1'b0;
        end
        else
        begin
            PANEL_KEY_OK <= PANEL_KEY & ~remote_ff; // RULE16
            PANEL_RESET <= dev_clr; // RULE13
            EXEC_TRIG <= cmd_take & (b7 == MSG_GET) & lads_ff; // RULE14
        end
    end

    assign REMOTE_LED = remote_ff; // RULE16
    assign LOCKOUT = llo_ff;
    assign TALKER = tads_ff;
    assign LISTENER = lads_ff;

    // ----------------------------------------------------------------
    // Command parser
    // ----------------------------------------------------------------
    assign is_let = (BUS.dio >= CH_A) && (BUS.dio <= CH_Z);
    assign is_dig = (BUS.dio >= CH_0) && (BUS.dio <= CH_9);
    assign done = (BUS.dio == CH_LF) | (BUS.dio == CH_SEMI) | BUS.eoi; // RULE3

    always_comb
    begin
        nxt_ps = ps_ff;
        nxt_nch = nch_ff;
        nxt_code = code_ff;
        nxt_val = val_ff;
        if (is_let)
        begin
            if (ps_ff == P_CMD && nch_ff != 2'h2)
            begin
                nxt_code = {code_ff[7:0], BUS.dio}; // RULE4
                nxt_nch = nch_ff + 2'h1;
            end
            else
                nxt_ps = P_BAD; // RULE4
        end
        else if (is_dig)
        begin
            nxt_val = (val_ff << 3) + (val_ff << 1) + PARAM_W'(BUS.dio - CH_0); // RULE5
            nxt_ps = (ps_ff == P_BAD || nch_ff == 2'h0) ? P_BAD : P_PARAM;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST || BUS.ifc || dev_clr || (dat_take && done))
        begin
            ps_ff <= P_CMD; // RULE18
            nch_ff <= 2'h0;
            code_ff <= 16'h0000;
            val_ff <= '0;
        end
        else if (dat_take)
        begin
            ps_ff <= nxt_ps;
            nch_ff <= nxt_nch;
            code_ff <= nxt_code;
            val_ff <= nxt_val;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            CMD_VALID <= 1'b0;
            CMD_ERROR <= 1'b0;
            CMD_CODE <= 16'h0000;
            CMD_PARAM <= '0;
        end
        else
        begin
            CMD_VALID <= dat_take & done & (nxt_ps != P_BAD) & (nxt_nch != 2'h0); // RULE3 RULE6
            CMD_ERROR <= dat_take & done & (nxt_ps == P_BAD);
            if (dat_take && done)
            begin
                CMD_CODE <= nxt_code; // RULE4
                CMD_PARAM <= nxt_val; // RULE5
            end
        end
    end

    // ----------------------------------------------------------------
    // Talker, source handshake and service request
    // ----------------------------------------------------------------
    assign talking = tads_ff & ~BUS.atn;
    assign TX_READY = talking & ~spm_ff & ~have_ff; // RULE7
    assign sent = talking & (sh_ff == SH_DAV) & ~BUS.ndac;

    always_ff @(posedge REF_CLK)
    begin
        if (RST || BUS.ifc)
        begin
            have_ff <= 1'b0;
            is_sb_ff <= 1'b0;
            out_byte_ff <= 8'h00;
            out_eoi_ff <= 1'b0;
        end
        else if (sent)
            have_ff <= 1'b0;
        else if (talking && spm_ff && !have_ff && !sb_sent_ff)
        begin
            have_ff <= 1'b1; // RULE7
            is_sb_ff <= 1'b1;
            out_byte_ff <= {STATUS_BYTE[7], rsv_ff, STATUS_BYTE[5:0]};
            out_eoi_ff <= 1'b0;
        end
        else if (TX_READY && TX_VALID)
        begin
            have_ff <= 1'b1; // RULE7
            is_sb_ff <= 1'b0;
            out_byte_ff <= TX_DATA;
            out_eoi_ff <= TX_LAST;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST || (cmd_take && b7 == MSG_SPE))
            sb_sent_ff <= 1'b0;
        else if (sent && is_sb_ff)
            sb_sent_ff <= 1'b1;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST || !talking)
        begin
            sh_ff <= SH_IDLE;
            settle_ff <= 16'h0000;
        end
        else
        begin
            unique case (sh_ff)
                SH_IDLE:
                    if (have_ff && !sent)
                    begin
                        sh_ff <= SH_SETTLE;
                        settle_ff <= 16'h0000;
                    end
                SH_SETTLE:
                begin
                    if (settle_ff != 16'(SETTLE_CYC - 1))
                        settle_ff <= settle_ff + 16'h0001;
                    else if (!BUS.nrfd)
                        sh_ff <= SH_DAV; // RULE8
                end
                SH_DAV:
                    if (!BUS.ndac)
                        sh_ff <= SH_IDLE; // RULE8
            endcase
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            rsv_ff <= 1'b0;
        else if (SRQ_REQ)
            rsv_ff <= 1'b1; // RULE8
        else if (sent && is_sb_ff)
            rsv_ff <= 1'b0;
    end

    assign drive = talking & (sh_ff != SH_IDLE);
    assign BUS.dev_dio_o = out_byte_ff;
    assign BUS.dev_dio_oe_n = ~{8{drive}};
    assign BUS.dev_dav_o = 1'b1;
    assign BUS.dev_dav_oe_n = ~(talking & (sh_ff == SH_DAV));
    assign BUS.dev_eoi_o = out_eoi_ff;
    assign BUS.dev_eoi_oe_n = ~drive;
    assign BUS.dev_srq_o = 1'b1;
    assign BUS.dev_srq_oe_n = ~rsv_ff; // RULE8
endmodule

// >>> hdl/remote_port_ctl.sv
// Controller end of the instrument bus, driven by software over classic Wishbone.
// Assumes Wishbone signals synchronous to REF_CLK; one interrupt output to the host.
`timescale 1ns/1ps
module remote_port_ctl
    import bus488_pkg::*;
#(
    parameter int unsigned IFC_CYCLES = IFC_CYC
)
(
    bus488_if.ctl BUS,
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    output logic IRQ
);
    logic ren_ff, atn_ff, listen_ff, tx_have_ff, tx_eoi_ff, srq_d_ff;
    logic [7:0] tx_byte_ff;
    logic [8:0] rx_ff;
    logic [15:0] ifc_ff, settle_ff;
    logic [2:0] ist_ff, imask_ff, ev;
    ah_state_t ah_ff;
    sh_state_t sh_ff;
    logic wr, accepting, take, sent;

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------
    assign wr = CYC_I & STB_I & WE_I & ACK_O & SEL_I[0];

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h0000_0000;
        end
        else
        begin
            ACK_O <= CYC_I & STB_I & ~ACK_O;
            unique case (ADR_I)
                REG_CTRL: DAT_O <= {29'h0, listen_ff, atn_ff, ren_ff};
                REG_RX: DAT_O <= {23'h0, rx_ff};
                REG_STAT: DAT_O <= {29'h0, ifc_ff != 16'h0000, BUS.srq, tx_have_ff};
                REG_IRQ_STAT: DAT_O <= {29'h0, ist_ff};
                REG_IRQ_MASK: DAT_O <= {29'h0, imask_ff};
                default: DAT_O <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            ren_ff <= 1'b0;
            atn_ff <= 1'b0;
            listen_ff <= 1'b0;
            imask_ff <= 3'h0;
        end
        else if (wr && ADR_I == REG_CTRL)
        begin
            ren_ff <= DAT_I[CTRL_REN];
            atn_ff <= DAT_I[CTRL_ATN];
            listen_ff <= DAT_I[CTRL_LISTEN];
        end
        else if (wr && ADR_I == REG_IRQ_MASK)
            imask_ff <= DAT_I[2:0];
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            ifc_ff <= 16'h0000;
        else if (wr && ADR_I == REG_CTRL && DAT_I[CTRL_IFC])
            ifc_ff <= 16'(IFC_CYCLES);
        else if (ifc_ff != 16'h0000)
            ifc_ff <= ifc_ff - 16'h0001;
    end

    // ----------------------------------------------------------------
    // Source handshake
    // ----------------------------------------------------------------
    assign sent = (sh_ff == SH_DAV) & ~BUS.ndac;

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            tx_have_ff <= 1'b0;
            tx_byte_ff <= 8'h00;
            tx_eoi_ff <= 1'b0;
        end
        else if (sent)
            tx_have_ff <= 1'b0;
        else if (wr && ADR_I == REG_TX && !tx_have_ff)
        begin
            tx_have_ff <= 1'b1;
            tx_byte_ff <= DAT_I[7:0];
            tx_eoi_ff <= DAT_I[TX_EOI];
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            sh_ff <= SH_IDLE;
            settle_ff <= 16'h0000;
        end
        else
        begin
            unique case (sh_ff)
                SH_IDLE:
                    if (tx_have_ff && !sent)
                    begin
                        sh_ff <= SH_SETTLE;
                        settle_ff <= 16'h0000;
                    end
                SH_SETTLE:
                begin
                    if (settle_ff != 16'(SETTLE_CYC - 1))
                        settle_ff <= settle_ff + 16'h0001;
                    else if (!BUS.nrfd)
                        sh_ff <= SH_DAV;
                end
                SH_DAV:
                    if (!BUS.ndac)
                        sh_ff <= SH_IDLE;
            endcase
        end
    end

    assign BUS.ctl_dio_o = tx_byte_ff;
    assign BUS.ctl_dio_oe_n = ~{8{sh_ff != SH_IDLE}};
    assign BUS.ctl_dav_o = 1'b1;
    assign BUS.ctl_dav_oe_n = ~(sh_ff == SH_DAV);
    assign BUS.ctl_eoi_o = tx_eoi_ff;
    assign BUS.ctl_eoi_oe_n = ~(sh_ff != SH_IDLE);
    assign BUS.ctl_atn = atn_ff;
    assign BUS.ctl_ren = ren_ff;
    assign BUS.ctl_ifc = ifc_ff != 16'h0000;

    // ----------------------------------------------------------------
    // Acceptor handshake
    // ----------------------------------------------------------------
    assign accepting = listen_ff & ~atn_ff;
    assign take = accepting & BUS.dav & (ah_ff == AH_RDY);

    always_ff @(posedge REF_CLK)
    begin
        if (RST || !accepting)
            ah_ff <= AH_RDY;
        else if (take)
            ah_ff <= AH_HOLD;
        else if (ah_ff == AH_HOLD && !BUS.dav)
            ah_ff <= AH_RDY;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            rx_ff <= 9'h000;
        else if (take)
            rx_ff <= {BUS.eoi, BUS.dio};
    end

    assign BUS.ctl_nrfd_o = 1'b1;
    assign BUS.ctl_nrfd_oe_n = ~(accepting & (ah_ff == AH_HOLD));
    assign BUS.ctl_ndac_o = 1'b1;
    assign BUS.ctl_ndac_oe_n = ~(accepting & (ah_ff == AH_RDY));

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    always_comb
    begin
        ev = 3'h0;
        ev[EV_TX_DONE] = sent;
        ev[EV_RX] = take;
        ev[EV_SRQ] = BUS.srq & ~srq_d_ff;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            ist_ff <= 3'h0;
            srq_d_ff <= 1'b0;
        end
        else
        begin
            srq_d_ff <= BUS.srq;
            if (wr && ADR_I == REG_IRQ_STAT)
                ist_ff <= (ist_ff & ~DAT_I[2:0]) | ev;
            else
                ist_ff <= ist_ff | ev;
        end
    end

    assign IRQ = |(ist_ff & imask_ff);
endmodule

// >>> bench/bus488_assertions.sv
// Handshake checks on the shared instrument bus lines.
// Assumes the resolved lines of the interface and one clock.
`timescale 1ns/1ps
module bus488_assertions
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [7:0] dio,
    input wire logic dav,
    input wire logic nrfd,
    input wire logic ndac,
    input wire logic atn,
    input wire logic ifc,
    input wire logic dev_dav_o,
    input wire logic dev_dav_oe_n
);
    // --------------------
    // Handshake rules
    // --------------------
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    a_dev_atn_quiet: assert property (atn && $past(atn) |-> !(!dev_dav_oe_n && dev_dav_o))
        else $error("device sourced a byte under attention");
    a_dev_ifc_quiet: assert property (ifc |=> !(!dev_dav_oe_n && dev_dav_o))
        else $error("device still sources after clear");
    a_dav_needs_ready: assert property ($rose(dav) |-> !$past(nrfd))
        else $error("valid raised while not ready");
    a_dio_stable: assert property (dav && $past(dav) |-> $stable(dio))
        else $error("data moved while valid");
    a_dav_settle: assert property ($rose(dav) |-> dio == $past(dio, 150))
        else $error("data not settled before valid");
    a_dav_release: assert property (dav && !ndac |=> !dav)
        else $error("valid held after accept");
    a_accept_hold: assert property (dav && !ndac |-> nrfd)
        else $error("acceptor ready before valid dropped");
    a_accept_bound: assert property ($rose(dav) |-> ##[1:4] !ndac)
        else $error("acceptor too slow");
endmodule

// >>> bench/ieee488_remote_command_port_bench.sv
// Self-checking bench: controller end over Wishbone, device end on its user ports.
// Assumes package, interface, both ends and the checker compiled first.
`timescale 1ns/1ps
module ieee488_remote_command_port_bench;
    import bus488_pkg::*;
    logic clk, rst, cyc, stb, we, ack, irq, lk, pk, tv, tl, tr, pko, led, llo, tlk, lsn, cv, ce, et, pr, sq;
    logic [7:0] adr, td;
    logic [15:0] code, cc;
    logic [31:0] wd, rdat, rdv, par, cp;
    int miscompares = 0, n_checks = 0, nv = 0, ne = 0, nt = 0, np = 0, nk = 0;
    bus488_if bus();
    remote_port_ctl #(.IFC_CYCLES(20)) remote_port_ctl_i (.BUS(bus), .REF_CLK(clk), .RST(rst), .CYC_I(cyc),
        .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hf), .DAT_I(wd), .DAT_O(rdat), .ACK_O(ack), .IRQ(irq));
    remote_port_dev remote_port_dev_i (.BUS(bus), .REF_CLK(clk), .RST(rst), .ADDR(5'h05), .LOCAL_KEY(lk),
        .PANEL_KEY(pk), .PANEL_KEY_OK(pko), .REMOTE_LED(led), .LOCKOUT(llo), .TALKER(tlk), .LISTENER(lsn),
        .CMD_VALID(cv), .CMD_ERROR(ce), .CMD_CODE(cc), .CMD_PARAM(cp), .EXEC_TRIG(et), .PANEL_RESET(pr),
        .TX_DATA(td), .TX_LAST(tl), .TX_VALID(tv), .TX_READY(tr), .STATUS_BYTE(8'h00), .SRQ_REQ(sq));
    bus488_assertions bus488_assertions_i (.REF_CLK(clk), .RST(rst), .dio(bus.dio), .dav(bus.dav),
        .nrfd(bus.nrfd), .ndac(bus.ndac), .atn(bus.atn), .ifc(bus.ifc), .dev_dav_o(bus.dev_dav_o),
        .dev_dav_oe_n(bus.dev_dav_oe_n));
    // --------------------
    // Monitors and tasks
    // --------------------
    always @(posedge clk)
    begin
        if (cv === 1'b1)
        begin
            code <= cc;
            par <= cp;
        end
        nv <= nv + (cv === 1'b1);
        ne <= ne + (ce === 1'b1);
        nt <= nt + (et === 1'b1);
        np <= np + (pr === 1'b1);
        nk <= nk + (pko === 1'b1);
    end
    task automatic finish_test;
        if (miscompares == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic wbc(input logic [7:0] a, input logic [31:0] d, input logic w);
        @(posedge clk);
        {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
        do @(posedge clk); while (ack !== 1'b1);
        rdv = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic sb(input logic [8:0] b);
        wbc(REG_TX, {23'h0, b}, 1'b1);
        do wbc(REG_STAT, 32'h0, 1'b0); while (rdv[0] !== 1'b0);
    endtask
    task automatic cmd(input string s, input bit e);
        for (int i = 0; i < s.len(); i++)
            sb({e && i == s.len() - 1, s[i]});
    endtask
    task automatic key(input bit l);
        {lk, pk} <= {l, !l};
        @(posedge clk);
        {lk, pk} <= 2'b00;
        repeat (4) @(posedge clk);
    endtask
    task automatic t_cmd;
        wbc(REG_CTRL, 32'h3, 1'b1);
        sb(9'h025);
        wbc(REG_CTRL, 32'h1, 1'b1);
        cmd("UP12;", 1'b0);
        chk({code, par[15:0]}, 32'h5550000c);
        cmd("S7", 1'b1);
        chk({code, par[15:0]}, 32'h00530007);
        cmd("ABC\n", 1'b0);
        chk({ne[3:0], led, lsn, nv[1:0]}, 8'h1e);
    endtask
    task automatic t_keys;
        key(1'b0);
        chk(nk, 0);
        wbc(REG_CTRL, 32'h3, 1'b1);
        sb(9'h011);
        key(1'b1);
        chk({led, llo}, 2'b11);
        sb(9'h004);
        sb(9'h008);
        chk({np[3:0], nt[3:0]}, 8'h11);
        sb(9'h001);
        chk(led, 1'b0);
        wbc(REG_CTRL, 32'h0, 1'b1);
        wbc(REG_CTRL, 32'h3, 1'b1);
        sb(9'h025);
        key(1'b1);
        key(1'b0);
        chk({led, llo, nk[3:0]}, 6'h01);
    endtask
    task automatic t_talk;
        sb(9'h045);
        chk({tlk, lsn}, 2'b10);
        wbc(REG_IRQ_MASK, 32'h2, 1'b1);
        sq <= 1'b1;
        sb(9'h018);
        sq <= 1'b0;
        wbc(REG_CTRL, 32'h5, 1'b1);
        do @(posedge clk); while (irq !== 1'b1);
        wbc(REG_RX, 32'h0, 1'b0);
        chk(rdv[8:0], 9'h040);
        wbc(REG_STAT, 32'h0, 1'b0);
        chk(rdv[2:0], 3'h0);
        wbc(REG_IRQ_STAT, 32'h2, 1'b1);
        wbc(REG_CTRL, 32'h3, 1'b1);
        sb(9'h019);
        wbc(REG_CTRL, 32'h5, 1'b1);
        {td, tl, tv} <= 10'h297;
        do @(posedge clk); while (tr !== 1'b1);
        tv <= 1'b0;
        do @(posedge clk); while (irq !== 1'b1);
        wbc(REG_RX, 32'h0, 1'b0);
        chk(rdv[8:0], 9'h1a5);
        wbc(REG_IRQ_STAT, 32'h2, 1'b1);
        @(posedge clk);
        chk(irq, 1'b0);
        wbc(REG_CTRL, 32'h3, 1'b1);
        sb(9'h025);
        chk({tlk, lsn}, 2'b01);
        wbc(REG_CTRL, 32'hb, 1'b1);
        repeat (30) @(posedge clk);
        chk({tlk, lsn}, 2'b00);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        miscompares++;
        finish_test();
    end
    initial
    begin
        rst = 1'b1;
        {cyc, stb, we, lk, pk, tv, tl, adr, wd, td, sq} = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({tlk, lsn, led, llo, irq}, 5'h0);
        t_cmd();
        t_keys();
        t_talk();
        finish_test();
    end
endmodule
